// file: ska_amp_keying.sv
// Amplitude scaling, shaped keying ramp and converter controls
`timescale 1ns/10ps
`default_nettype none
module ska_amp_keying import ska_pkg::*; #(
  parameter int FIFO_D = FIFO_DEPTH
) (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset, high
  input wire logic [ADDR_W-1:0] host_addr, // Register address
  input wire logic host_wr, // Write strobe
  input wire logic host_rd, // Read strobe
  input wire logic [7:0] host_wdata, // Write byte
  output logic [7:0] host_rdata, // Read byte
  input wire logic keying_pin, // Shaped keying pin, asynchronous
  input wire logic [SMP_W-1:0] smp_in_data, // Sample in, two's complement
  input wire logic smp_in_valid, // Sample in valid
  output logic smp_in_ready, // Sample in ready
  output logic [SMP_W-1:0] smp_out_data, // Sample to main converter
  output logic smp_out_valid, // Sample out valid
  input wire logic smp_out_ready, // Converter takes sample
  output logic [SMP_W-1:0] aux_dac_data, // Auxiliary converter word
  output logic main_converter_powerdown, // Main converter off
  output logic aux_converter_powerdown, // Auxiliary converter off
  output logic [FACT_W-1:0] clkmult_factor, // Clock multiplication factor
  output logic clkmult_factor_ok, // Factor within 4..20
  output logic clkmult_enable, // Clock multiplier engaged
  output logic sysclk_from_ref, // System clock taken from reference
  output logic pll_range, // Multiplier range select
  output logic [SCALE_W-1:0] scale_now // Scale fed to the multiplier
);
  logic [7:0] pwr_q;
  logic [7:0] clk_q;
  logic [7:0] path_q;
  logic [RATE_W-1:0] rate_n_q;
  logic [HI_W-1:0] scale_hi_q;
  logic [7:0] scale_lo_q;
  logic [HI_W-1:0] aux_hi_q;
  logic [7:0] aux_lo_q;
  logic [7:0] rdata_q;

  logic key_s1_q;
  logic key_s2_q;
  logic key_s3_q;
  logic key_q;

  logic [RATE_W-1:0] rate_q;
  logic rate_pulse;
  logic [SCALE_W-1:0] step_q;
  ska_ramp_t ramp_q;
  ska_ramp_t ramp_d;
  logic [SCALE_W-1:0] scale_q;

  logic mult_en;
  logic int_ramp;
  logic ramp_run;
  logic sinc_byp;
  logic [SCALE_W-1:0] user_scale;

  ska_smp_t hist1_q;
  ska_smp_t hist2_q;
  ska_smp_t s1_data_q;
  logic s1_valid_q;
  ska_smp_t out_data_q;
  logic out_valid_q;
  logic adv;
  logic [SMP_W-1:0] aux_q;

  ska_stream_if #(.W(SMP_W)) in_if ();
  ska_stream_if #(.W(SMP_W)) out_if ();

  assign mult_en = path_q[PATH_MULT_EN_BIT];
  assign int_ramp = path_q[PATH_INT_RAMP_BIT];
  assign sinc_byp = path_q[PATH_SINC_BYP_BIT];
  assign ramp_run = mult_en && int_ramp;
  assign user_scale = {scale_hi_q, scale_lo_q};

  // Host register writes
  always_ff @(posedge clock) begin
    if (rst) begin
      pwr_q <= PWR_RST;
      clk_q <= CLK_RST;
      path_q <= PATH_RST;
      rate_n_q <= RATE_RST;
      scale_hi_q <= '0;
      scale_lo_q <= '0;
      aux_hi_q <= '0;
      aux_lo_q <= '0;
    end else if (host_wr) begin
      case (host_addr)
        REG_PWR: pwr_q <= host_wdata;
        REG_CLK: clk_q <= host_wdata;
        REG_PATH: path_q <= host_wdata;
        REG_RATE: rate_n_q <= host_wdata;
        REG_SCALE_HI: scale_hi_q <= host_wdata[HI_W-1:0];
        REG_SCALE_LO: scale_lo_q <= host_wdata;
        REG_AUX_HI: aux_hi_q <= host_wdata[HI_W-1:0];
        REG_AUX_LO: aux_lo_q <= host_wdata;
        default: ;
      endcase
    end
  end

  // Read data is held until the next read strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (host_rd) begin
      case (host_addr)
        REG_PWR: rdata_q <= pwr_q;
        REG_CLK: rdata_q <= clk_q;
        REG_PATH: rdata_q <= path_q;
        REG_RATE: rdata_q <= rate_n_q;
        REG_SCALE_HI: rdata_q <= {4'h0, scale_hi_q};
        REG_SCALE_LO: rdata_q <= scale_lo_q;
        REG_AUX_HI: rdata_q <= {4'h0, aux_hi_q};
        REG_AUX_LO: rdata_q <= aux_lo_q;
        REG_STAT_HI: rdata_q <= {key_q, 1'b0, ramp_q, step_q[SCALE_W-1 -: HI_W]};
        REG_STAT_LO: rdata_q <= step_q[7:0];
        default: rdata_q <= 8'h00;
      endcase
    end
  end
  assign host_rdata = rdata_q;

  // Keying pin: three stages, a change counts once stages two and three agree
  always_ff @(posedge clock) begin
    if (rst) begin
      key_s1_q <= 1'b0;
      key_s2_q <= 1'b0;
      key_s3_q <= 1'b0;
      key_q <= 1'b0;
    end else begin
      key_s1_q <= keying_pin;
      key_s2_q <= key_s1_q;
      key_s3_q <= key_s2_q;
      if (key_s2_q == key_s3_q) key_q <= key_s3_q;
    end
  end

  // Rate counter: reload at zero gives a period of count plus one
  always_ff @(posedge clock) begin
    if (rst) begin
      rate_q <= RATE_RST;
    end else if (!ramp_run || rate_q == '0) begin
      rate_q <= rate_n_q;
    end else begin
      rate_q <= rate_q - 1'b1;
    end
  end
  assign rate_pulse = ramp_run && rate_q == '0;

  // Step counter holds at the ends instead of wrapping
  always_ff @(posedge clock) begin
    if (rst) begin
      step_q <= SCALE_ZERO;
    end else if (rate_pulse) begin
      if (key_q && step_q != SCALE_FULL) begin
        step_q <= step_q + SCALE_ONE;
      end else if (!key_q && step_q != SCALE_ZERO) begin
        step_q <= step_q - SCALE_ONE;
      end
    end
  end

  always_comb begin
    if (key_q) begin
      ramp_d = (step_q == SCALE_FULL) ? RMP_HIGH : RMP_RISE;
    end else begin
      ramp_d = (step_q == SCALE_ZERO) ? RMP_LOW : RMP_FALL;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ramp_q <= RMP_LOW;
    end else begin
      unique case (ramp_d)
        RMP_LOW: ramp_q <= RMP_LOW;
        RMP_RISE: ramp_q <= RMP_RISE;
        RMP_HIGH: ramp_q <= RMP_HIGH;
        RMP_FALL: ramp_q <= RMP_FALL;
      endcase
    end
  end

  // Scale source; bypass is modelled as unity scale
  always_ff @(posedge clock) begin
    if (rst) begin
      scale_q <= SCALE_FULL;
    end else if (!mult_en) begin
      scale_q <= SCALE_FULL;
    end else if (int_ramp) begin
      scale_q <= step_q;
    end else begin
      scale_q <= user_scale;
    end
  end
  assign scale_now = scale_q;

  function automatic ska_smp_t inv_sinc(input ska_smp_t xn, input ska_smp_t xc, input ska_smp_t xo);
    ska_acc_t acc;
    acc = ska_acc_t'(xc) + (ska_acc_t'(xc) >>> SINC_CTR_SHIFT)
        - ((ska_acc_t'(xn) + ska_acc_t'(xo)) >>> SINC_SIDE_SHIFT);
    if (acc > ska_acc_t'(SMP_MAX)) return SMP_MAX;
    if (acc < ska_acc_t'(SMP_MIN)) return SMP_MIN;
    return acc[SMP_W-1:0];
  endfunction : inv_sinc

  // All ones is exact unity; other codes use the code over 4096
  function automatic ska_smp_t scale_smp(input ska_smp_t x, input logic [SCALE_W-1:0] s);
    logic signed [SMP_W+SCALE_W:0] p;
    p = x * $signed({1'b0, s});
    if (s == SCALE_FULL) return x;
    return p[SCALE_W +: SMP_W];
  endfunction : scale_smp

  ska_fifo #(.W(SMP_W), .DEPTH(FIFO_D)) u_fifo (
    .clock(clock),
    .rst(rst),
    .wr(in_if.snk),
    .rd(out_if.src)
  );

  assign in_if.valid = smp_in_valid;
  assign in_if.data = smp_in_data;
  assign smp_in_ready = in_if.ready;
  // Whole pipeline stalls together when the converter holds off
  assign adv = !out_valid_q || smp_out_ready;
  assign out_if.ready = adv;

  // Stage one: inverse-sinc ahead of the multiplier
  always_ff @(posedge clock) begin
    if (rst) begin
      hist1_q <= '0;
      hist2_q <= '0;
      s1_data_q <= '0;
      s1_valid_q <= 1'b0;
    end else if (adv) begin
      s1_valid_q <= out_if.valid;
      if (out_if.valid) begin
        hist1_q <= out_if.data;
        hist2_q <= hist1_q;
        if (sinc_byp) begin
          s1_data_q <= out_if.data;
        end else begin
          s1_data_q <= inv_sinc(out_if.data, hist1_q, hist2_q);
        end
      end
    end
  end

  // Stage two: multiplier, then out to the main converter
  always_ff @(posedge clock) begin
    if (rst) begin
      out_data_q <= '0;
      out_valid_q <= 1'b0;
    end else if (adv) begin
      out_valid_q <= s1_valid_q;
      if (s1_valid_q) out_data_q <= scale_smp(s1_data_q, scale_q);
    end
  end
  assign smp_out_data = out_data_q;
  assign smp_out_valid = out_valid_q;

  // Auxiliary converter word refreshed every clock while powered
  always_ff @(posedge clock) begin
    if (rst) begin
      aux_q <= '0;
    end else if (!aux_converter_powerdown) begin
      aux_q <= {aux_hi_q, aux_lo_q};
    end
  end
  assign aux_dac_data = aux_q;

  assign main_converter_powerdown = pwr_q[PWR_MAIN_BIT];
  assign aux_converter_powerdown = pwr_q[PWR_MAIN_BIT] || pwr_q[PWR_AUX_BIT];

  // Out-of-range factors fall back to the reference rather than a bad lock
  assign clkmult_factor = clk_q[CLK_FACT_LSB +: FACT_W];
  assign clkmult_factor_ok = clkmult_factor >= FACT_MIN && clkmult_factor <= FACT_MAX;
  assign clkmult_enable = !clk_q[CLK_BYP_BIT] && clkmult_factor_ok;
  assign sysclk_from_ref = !clkmult_enable;
  assign pll_range = clk_q[CLK_RANGE_BIT];

  default clocking dc @(posedge clock);
  endclocking
  default disable iff (rst);

  a_bypass_full_scale: assert property (
    !mult_en |=> scale_q == SCALE_FULL) else $error("Scale not full in bypass");

  a_user_scale_src: assert property (
    mult_en && !int_ramp |=> scale_q == $past(user_scale)) else $error("User scale not used");

  a_ramp_scale_src: assert property (
    ramp_run |=> scale_q == $past(step_q)) else $error("Ramp scale not used");

  a_rate_reload: assert property (
    rate_pulse |=> rate_q == $past(rate_n_q)) else $error("Rate counter did not reload");

  a_rate_period: assert property (
    ramp_run && rate_q == 8'h02 && $stable(path_q) ##1 ramp_run |=> rate_q == 8'h00 && rate_pulse)
    else $error("Rate pulse period wrong");

  a_step_up_one: assert property (
    rate_pulse && key_q && step_q != SCALE_FULL |=> step_q == $past(step_q) + SCALE_ONE)
    else $error("Step counter did not advance");

  a_step_top_hold: assert property (
    key_q && step_q == SCALE_FULL |=> step_q == SCALE_FULL) else $error("Step wrapped at top");

  a_step_zero_hold: assert property (
    !key_q && step_q == SCALE_ZERO |=> step_q == SCALE_ZERO) else $error("Step wrapped at zero");

  a_zero_scale_out: assert property (
    adv && s1_valid_q && scale_q == SCALE_ZERO |=> out_data_q == '0)
    else $error("Zero scale gave nonzero output");

  a_unity_scale_out: assert property (
    adv && s1_valid_q && scale_q == SCALE_FULL |=> out_data_q == $past(s1_data_q))
    else $error("Full scale not unity");

  a_sinc_bypass_path: assert property (
    adv && out_if.valid && sinc_byp |=> s1_data_q == $past(out_if.data))
    else $error("Inverse-sinc not bypassed");

  a_main_pd_both: assert property (
    main_converter_powerdown |-> aux_converter_powerdown) else $error("Aux not down");

  a_aux_word_follow: assert property (
    !aux_converter_powerdown |=> aux_dac_data == $past({aux_hi_q, aux_lo_q}))
    else $error("Aux word not refreshed");

  c_ramp_reaches_full: cover property (ramp_q == RMP_RISE ##1 ramp_q == RMP_HIGH);
  c_ramp_back_to_zero: cover property (ramp_q == RMP_FALL ##1 ramp_q == RMP_LOW);
  c_user_scaled_out: cover property (mult_en && !int_ramp && smp_out_valid && smp_out_ready);
  c_fifo_backpressure: cover property (smp_in_valid && !smp_in_ready);
endmodule : ska_amp_keying
`default_nettype wire

// file: ska_amp_keying_tb.sv
// Self-checking bench for the amplitude keying block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) \
  begin \
    n_tests++; \
    if ((a) !== (b)) begin \
      err_count++; \
      $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); \
    end \
  end
module ska_amp_keying_tb import ska_pkg::*; ;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [ADDR_W-1:0] host_addr;
  logic host_wr, host_rd, keying_pin, smp_in_ready, smp_out_valid;
  logic [7:0] host_wdata, host_rdata;
  logic [SMP_W-1:0] smp_in_data = 12'h000;
  logic smp_in_valid = 1'h0;
  logic smp_out_ready = 1'h0;
  logic stall = 1'h0;
  logic [SMP_W-1:0] smp_out_data, aux_dac_data;
  logic [SCALE_W-1:0] scale_now;
  logic [FACT_W-1:0] clkmult_factor;
  logic main_converter_powerdown, aux_converter_powerdown;
  logic clkmult_factor_ok, clkmult_enable, sysclk_from_ref, pll_range;
  int err_count = 0;
  int n_tests = 0;
  logic [12:0] sq[$];
  logic [7:0] rq[$];
  logic [12:0] se;
  logic rd_seen = 1'h0;
  always #50 clock = ~clock;
  ska_host_model host (.clock(clock), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .keying_pin(keying_pin));
  ska_amp_keying DUT (.clock(clock), .rst(rst), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .keying_pin(keying_pin), .smp_in_data(smp_in_data), .smp_in_valid(smp_in_valid),
    .smp_in_ready(smp_in_ready), .smp_out_data(smp_out_data), .smp_out_valid(smp_out_valid),
    .smp_out_ready(smp_out_ready), .aux_dac_data(aux_dac_data),
    .main_converter_powerdown(main_converter_powerdown),
    .aux_converter_powerdown(aux_converter_powerdown), .clkmult_factor(clkmult_factor),
    .clkmult_factor_ok(clkmult_factor_ok), .clkmult_enable(clkmult_enable),
    .sysclk_from_ref(sysclk_from_ref), .pll_range(pll_range), .scale_now(scale_now));
  // Random back-pressure from the converter side
  always @(posedge clock) smp_out_ready <= !stall && ($urandom % 4 != 0);
  always @(posedge clock) rd_seen <= host_rd;
  always @(negedge clock) begin
    if (rd_seen) `CHK(host_rdata, rq.pop_front())
    if (smp_out_valid === 1'h1 && smp_out_ready === 1'h1) begin
      se = sq.pop_front();
      if (se[12] === 1'h0) `CHK(smp_out_data, se[11:0])
    end
  end
  task automatic test_done;
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    rq.push_back(e);
    host.rd(a);
  endtask : rd
  // Caller stands at a rising edge
  task automatic send(input logic [11:0] x, input logic [12:0] e);
    int k;
    k = 0;
    sq.push_back(e);
    smp_in_data <= x;
    smp_in_valid <= 1'h1;
    @(negedge clock);
    while (smp_in_ready !== 1'h1 && k < 300) begin
      @(negedge clock);
      k++;
    end
    @(posedge clock);
  endtask : send
  task automatic idle;
    int k;
    smp_in_valid <= 1'h0;
    smp_in_data <= ~smp_in_data;
    k = 0;
    while (sq.size() > 0 && k < 500) begin
      @(negedge clock);
      k++;
    end
    `CHK(sq.size(), 0)
  endtask : idle
  function automatic logic [11:0] mul(input logic [11:0] x, input logic [11:0] s);
    int p;
    p = int'($signed(x)) * int'(s);
    return (s == SCALE_FULL) ? x : 12'(p >>> 12);
  endfunction : mul
  task automatic ramp(input logic up, input int n);
    logic [11:0] last, tgt;
    int c, steps, g;
    tgt = up ? SCALE_FULL : SCALE_ZERO;
    c = 0;
    steps = 0;
    g = 0;
    host.key(up);
    @(negedge clock);
    last = scale_now;
    while (last !== tgt && g < 30000) begin
      @(negedge clock);
      g++;
      c++;
      if (scale_now !== last) begin
        if (steps > 0) `CHK(c, n + 1)
        `CHK(scale_now, up ? 12'(last + 1) : 12'(last - 1))
        steps++;
        c = 0;
        last = scale_now;
      end
    end
    `CHK(steps, 4095)
    repeat (40) @(negedge clock);
    `CHK(scale_now, tgt)
  endtask : ramp
  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    test_done();
  end
  initial begin
    logic [11:0] v, av, x, s;
    logic b, ok;
    int m;
    static logic [11:0] st[5] = '{12'h000, 12'h001, 12'h800, 12'hFFE, 12'hFFF};
    void'($urandom(32'h025BD245));
    av = 12'h000;
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    @(negedge clock);
    `CHK({clkmult_factor, clkmult_enable, sysclk_from_ref, pll_range}, 8'h22)
    `CHK({main_converter_powerdown, aux_converter_powerdown, scale_now}, 14'h0FFF)
    rd(REG_PWR, PWR_RST);
    rd(REG_CLK, CLK_RST);
    rd(REG_PATH, PATH_RST);
    rd(REG_RATE, RATE_RST);
    rd(6'h3F, 8'h00);
    host.wr(REG_STAT_HI, 8'hFF);
    rd(REG_STAT_HI, 8'h00);
    for (int f = 0; f < 32; f++) begin
      m = 5 + $urandom % 296;
      b = 1'($urandom);
      ok = f >= 4 && f <= 20;
      host.cfg_clk(f[4:0], b, m);
      @(negedge clock);
      `CHK({clkmult_factor, clkmult_factor_ok, clkmult_enable, sysclk_from_ref, pll_range}, {f[4:0], ok, ~b & ok, ~(~b & ok), m >= 200})
      rd(REG_CLK, {1'h0, m >= 200, b, f[4:0]});
    end
    for (int p = 0; p < 4; p++) begin
      host.wr(REG_PWR, {5'h00, p[1:0], 1'h0});
      v = 12'($urandom);
      host.wr12(REG_AUX_HI, v);
      if (p == 0) av = v;
      repeat (2) @(negedge clock);
      `CHK({main_converter_powerdown, aux_converter_powerdown}, {p[1], p[1] | p[0]})
      `CHK(aux_dac_data, av)
    end
    host.wr(REG_PATH, 8'h40);
    for (int i = 0; i < 6; i++) begin
      x = 12'($urandom);
      send(x, {1'h0, x});
    end
    idle();
    @(posedge clock);
    stall <= 1'h1;
    fork
      for (int i = 0; i < 8; i++) send(12'(i * 291), {1'h0, 12'(i * 291)});
      begin
        repeat (30) @(posedge clock);
        // Look between edges, where the FIFO count has settled
        @(negedge clock);
        `CHK(smp_in_ready, 1'h0)
        @(posedge clock);
        stall <= 1'h0;
      end
    join
    idle();
    host.wr(REG_PATH, 8'h60);
    foreach (st[j]) begin
      s = (j == 4) ? 12'($urandom) : st[j];
      host.wr12(REG_SCALE_HI, s);
      repeat (2) @(negedge clock);
      `CHK(scale_now, s)
      @(posedge clock);
      for (int i = 0; i < 4; i++) begin
        x = 12'($urandom);
        send(x, {1'h0, mul(x, s)});
      end
      idle();
    end
    host.wr12(REG_SCALE_HI, 12'h555);
    for (int c = 0; c < 2; c++) begin
      host.wr(REG_PATH, c ? 8'h20 : 8'h00);
      for (int i = 0; i < 10; i++) begin
        send(i % 2 ? 12'h000 : 12'h400, {i < 2, i % 2 ? (c ? 12'h17F : 12'h480) : (c ? 12'hFD5 : 12'hF80)});
      end
      idle();
    end
    host.wr(REG_RATE, 8'h05);
    host.key(1'h0);
    host.wr(REG_PATH, 8'h70);
    repeat (2) @(negedge clock);
    `CHK(scale_now, 12'h000)
    ramp(1'h1, 5);
    rd(REG_STAT_HI, 8'hAF);
    rd(REG_STAT_LO, 8'hFF);
    host.wr(REG_RATE, 8'h00);
    ramp(1'h0, 0);
    rd(REG_STAT_HI, 8'h00);
    rd(REG_STAT_LO, 8'h00);
    repeat (3) @(posedge clock);
    test_done();
  end
endmodule : ska_amp_keying_tb
`default_nettype wire

// file: ska_fifo.sv
// Small sample FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module ska_fifo import ska_pkg::*; #(
  parameter int W = 12,
  parameter int DEPTH = 4
) (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset, high
  ska_stream_if.snk wr, // Filling side
  ska_stream_if.src rd // Draining side
);
  // DEPTH must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign wr.ready = cnt_q != FULL_CNT;
  assign rd.valid = cnt_q != '0;
  assign rd.data = mem_q[rp_q];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wp_q] <= wr.data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_bound: assert property (@(posedge clock) disable iff (rst) cnt_q <= FULL_CNT)
    else $error("FIFO count above depth");
endmodule : ska_fifo
`default_nettype wire

// file: ska_host_model.sv
// Host controller model: register port transfers and keying pin
`timescale 1ns/10ps
`default_nettype none
module ska_host_model import ska_pkg::*; (
  input wire logic clock, // System clock
  output logic [ADDR_W-1:0] host_addr, // Register address
  output logic host_wr, // Write strobe
  output logic host_rd, // Read strobe
  output logic [7:0] host_wdata, // Write byte
  output logic keying_pin // Keying level
);
  initial begin
    host_addr = '0;
    host_wr = 1'h0;
    host_rd = 1'h0;
    host_wdata = 8'h00;
    keying_pin = 1'h0;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'h1;
    @(posedge clock);
    host_wr <= 1'h0;
    // Stale byte must not look like the last one
    host_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clock);
    host_addr <= a;
    host_rd <= 1'h1;
    @(posedge clock);
    host_rd <= 1'h0;
  endtask : rd
  // No atomic pairing, so a half-written word is briefly visible
  task automatic wr12(input logic [ADDR_W-1:0] a, input logic [11:0] v);
    wr(a, {4'h0, v[11:8]});
    wr(a + 6'h01, v[7:0]);
  endtask : wr12
  task automatic cfg_clk(input logic [4:0] f, input logic byp, input int mhz);
    wr(REG_CLK, {1'h0, mhz >= 200, byp, f});
  endtask : cfg_clk
  task automatic key(input logic v);
    @(posedge clock);
    keying_pin <= v;
  endtask : key
endmodule : ska_host_model
`default_nettype wire

// file: ska_pkg.sv
// Constants and types for the shaped keying amplitude path
// Notes on behaviour
// - Multiplier enable low: multiplier bypassed, samples pass at full scale.
// - Multiplier sits in the sample path only while its enable bit is high.
// - Enable high and internal ramp high: scale comes from the internal ramp.
// - Enable high and internal ramp low: scale comes from the host-written 12-bit scale word.
// - An 8-bit rate down-counter runs every clock while enable and internal ramp are high, pulsing when it reaches zero.
// - Each rate pulse steps the 12-bit step counter; its value is the scale.
// - Scale zero gives zero, all ones unity, other codes proportional output.
// - Rate pulses come every programmed count plus one clock periods.
// - A full ramp between zero and full scale spans 4096 amplitude levels.
// - Rate counter loads its value on the first edge, then decrements each edge.
// - Keying high ramps up to full and holds; keying low ramps down to zero.
// - Internal ramp ceiling is always full scale, no register changes it.
// - Sample order: inverse-sinc stage, then multiplier, then main converter.
// - Inverse-sinc is active after reset, bypassed while its bypass bit is high.
// - Main converter power-down bit powers down both converters.
// - Auxiliary power-down bit powers down only the auxiliary converter.
// - Auxiliary converter takes a 12-bit two's complement word every clock while powered; it holds while powered down.
// - Five-bit field sets the clock multiplication factor; only 4 to 20 valid.
// - System clock is the multiplier output when engaged, else the reference.
// - Multiplier bypass bit disables the clock multiplier, clocking from reference.
`default_nettype none
package ska_pkg;
  localparam int SMP_W = 12;
  localparam int SCALE_W = 12;
  localparam int RATE_W = 8;
  localparam int HI_W = 4;
  localparam int ADDR_W = 6;
  localparam int FIFO_DEPTH = 4;
  localparam int ACC_W = SMP_W + 3;
  localparam int FACT_W = 5;

  localparam logic [ADDR_W-1:0] REG_PWR = 6'h1D;
  localparam logic [ADDR_W-1:0] REG_CLK = 6'h1E;
  localparam logic [ADDR_W-1:0] REG_PATH = 6'h20;
  localparam logic [ADDR_W-1:0] REG_SCALE_HI = 6'h21;
  localparam logic [ADDR_W-1:0] REG_SCALE_LO = 6'h22;
  localparam logic [ADDR_W-1:0] REG_RATE = 6'h25;
  localparam logic [ADDR_W-1:0] REG_AUX_HI = 6'h26;
  localparam logic [ADDR_W-1:0] REG_AUX_LO = 6'h27;
  localparam logic [ADDR_W-1:0] REG_STAT_HI = 6'h28;
  localparam logic [ADDR_W-1:0] REG_STAT_LO = 6'h29;

  localparam int PWR_AUX_BIT = 1;
  localparam int PWR_MAIN_BIT = 2;
  localparam int CLK_FACT_LSB = 0;
  localparam int CLK_BYP_BIT = 5;
  localparam int CLK_RANGE_BIT = 6;
  localparam int PATH_INT_RAMP_BIT = 4;
  localparam int PATH_MULT_EN_BIT = 5;
  localparam int PATH_SINC_BYP_BIT = 6;
  localparam int STAT_KEY_BIT = 7;
  localparam int STAT_RAMP_LSB = 4;

  localparam logic [7:0] PWR_RST = 8'h00;
  localparam logic [7:0] CLK_RST = 8'h24;
  localparam logic [7:0] PATH_RST = 8'h00;
  localparam logic [RATE_W-1:0] RATE_RST = 8'h0F;

  localparam logic [FACT_W-1:0] FACT_MIN = 5'h04;
  localparam logic [FACT_W-1:0] FACT_MAX = 5'h14;

  localparam logic [SCALE_W-1:0] SCALE_FULL = 12'hFFF;
  localparam logic [SCALE_W-1:0] SCALE_ZERO = 12'h000;
  localparam logic [SCALE_W-1:0] SCALE_ONE = 12'h001;
  localparam logic signed [SMP_W-1:0] SMP_MAX = 12'sh7FF;
  localparam logic signed [SMP_W-1:0] SMP_MIN = 12'sh800;
  localparam int SINC_CTR_SHIFT = 3;
  localparam int SINC_SIDE_SHIFT = 4;

  typedef logic signed [ACC_W-1:0] ska_acc_t;
  typedef logic signed [SMP_W-1:0] ska_smp_t;

  typedef enum logic [1:0] {
    RMP_LOW = 2'b00,
    RMP_RISE = 2'b01,
    RMP_HIGH = 2'b10,
    RMP_FALL = 2'b11
  } ska_ramp_t;
endpackage : ska_pkg
`default_nettype wire

// file: ska_stream_if.sv
// Valid/ready sample stream between the block's own modules
`timescale 1ns/10ps
`default_nettype none
interface ska_stream_if #(parameter int W = 12);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ska_stream_if
`default_nettype wire
